// ===== verilog/arpm_pkg.sv
// Shared constants for the range and power-mode configuration bank.
// Assumes an 8-bit register access port driven by the serial interface core.
package arpm_pkg;

	// Register offsets on the serial register map
	localparam logic [7:0] ARPM_RANGE_RUN_ADDR = 8'h15;
	localparam logic [7:0] ARPM_POWER_FMT_ADDR = 8'h16;

	// Fields of range_and_run_control
	localparam int ARPM_ACTIVE_BIT = 0;
	localparam int ARPM_RANGE_LSB = 1;
	localparam int ARPM_RANGE_MSB = 2;

	// Fields of power_mode_and_output_format
	localparam int ARPM_FASTREAD_BIT = 0;
	localparam int ARPM_TEMPINC_BIT = 1;
	localparam int ARPM_SPARE_BIT = 2;
	localparam int ARPM_BYTEORDER_BIT = 3;
	localparam int ARPM_SLEEPPM_LSB = 4;
	localparam int ARPM_SLEEPPM_MSB = 5;
	localparam int ARPM_WAKEPM_LSB = 6;
	localparam int ARPM_WAKEPM_MSB = 7;

	// Reset values, and the value that unmapped offsets read
	localparam logic [1:0] ARPM_RANGE_RESET = 2'h1;
	localparam logic ARPM_ACTIVE_RESET = 1'b0;
	localparam logic [7:0] ARPM_POWER_FMT_RESET = 8'h00;
	localparam logic [7:0] ARPM_UNMAPPED_READ = 8'h00;

	// Range codes
	localparam logic [1:0] ARPM_RANGE_2G = 2'h0;
	localparam logic [1:0] ARPM_RANGE_4G = 2'h1;
	localparam logic [1:0] ARPM_RANGE_8G = 2'h2;
	localparam logic [1:0] ARPM_RANGE_16G = 2'h3;

	// Sensitivity at the narrowest range, halved for each step up
	localparam logic [10:0] ARPM_COUNTS_2G = 11'h400;

	// Power-select codes
	localparam logic [1:0] ARPM_PM_LOW_POWER = 2'h0;
	localparam logic [1:0] ARPM_PM_HIGH_PERF = 2'h1;

	// Sampling modes
	typedef enum logic [1:0] {
		ARPM_LOW_POWER_MODE,
		ARPM_HIGH_PERFORMANCE_MODE,
		ARPM_FLEXIBLE_MODE
	} arpm_mode_t;

endpackage

// ===== verilog/arpm_mode_decode.sv
// Decodes one power-select field and its rate nibble into a sampling mode.
// Assumes the select, nibble and idle time are steady register values.
`timescale 1ns/10ps
module arpm_mode_decode (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Configuration in
	input wire logic [1:0] powerSelect,
	input wire logic [3:0] rateNibble,
	input wire logic [11:0] idleTime,
	// Decoded settings out
	output arpm_pkg::arpm_mode_t mode,
	output logic [3:0] rateCode,
	output logic [3:0] decimationCode,
	output logic [11:0] flexIdleTime
);
	import arpm_pkg::*;

	// Next values of the registered outputs
	arpm_mode_t next_mode;
	logic [3:0] next_rateCode;
	logic [3:0] next_decimationCode;
	logic [11:0] next_flexIdleTime;

	// Upper select bit alone picks flexible mode, so 10b and 11b match
	always_comb begin
		next_rateCode = 4'h0;
		next_decimationCode = 4'h0;
		next_flexIdleTime = 12'h000;
		case (powerSelect)
			ARPM_PM_LOW_POWER: begin
				next_mode = ARPM_LOW_POWER_MODE;
				next_rateCode = rateNibble;
			end
			ARPM_PM_HIGH_PERF: begin
				next_mode = ARPM_HIGH_PERFORMANCE_MODE;
				next_rateCode = rateNibble;
			end
			default: begin
				next_mode = ARPM_FLEXIBLE_MODE;
				next_decimationCode = rateNibble;
				// Rate set jointly by decimation and idle time
				next_flexIdleTime = idleTime;
			end
		endcase
	end

	// Output registers; reset matches the low-power default
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode <= ARPM_LOW_POWER_MODE;
			rateCode <= 4'h0;
			decimationCode <= 4'h0;
			flexIdleTime <= 12'h000;
		end else begin
			mode <= next_mode;
			rateCode <= next_rateCode;
			decimationCode <= next_decimationCode;
			flexIdleTime <= next_flexIdleTime;
		end
	end

endmodule

// ===== verilog/arpm_config_regs.sv
// Range, run control and power-mode configuration registers.
// Assumes a register access port from the serial interface core, and the
// rate/decimation and idle-time registers held elsewhere and fed in.
// Bits 7..3 of range_and_run_control are not stored and read as zero.
//
// Operation
// - Range field selects 2, 4, 8, 16 g
// - Counts per g halve per larger range
// - Mode bit clear standby, set active
// - Standby after power-on and software reset
// - Pin mode: active read-only, pin decides
// - Wake select 00b: low-power, nibble is rate
// - Wake select 01b: high-performance, nibble rate
// - Wake select 1x: flexible, nibble is decimation
// - Flexible rate uses decimation plus idle time
// - Sleep select decodes likewise from low nibble
// - Byte order bit selects endianness, justification
// - Temperature burst include bit, default excluded
// - Fast read returns only most significant byte
`timescale 1ns/10ps
module arpm_config_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Software reset pulse from the reset sequencer
	input wire logic softReset,
	// Register access port from the serial interface core
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWriteData,
	output logic [7:0] regReadData,
	// Pin-controlled mode
	input wire logic pinModeControlEnable,
	input wire logic secondEventPin,
	// Rate/decimation register and idle times held elsewhere
	input wire logic [7:0] rateDecimationConfig,
	input wire logic [11:0] wakeIdleTime,
	input wire logic [11:0] sleepIdleTime,
	// Measurement control out
	output logic measureActive,
	output logic [1:0] rangeSelect,
	output logic [10:0] countsPerG,
	// Wake sampling settings
	output arpm_pkg::arpm_mode_t wakeMode,
	output logic [3:0] wakeRateCode,
	output logic [3:0] wakeDecimationCode,
	output logic [11:0] wakeFlexIdleTime,
	// Sleep sampling settings
	output arpm_pkg::arpm_mode_t sleepMode,
	output logic [3:0] sleepRateCode,
	output logic [3:0] sleepDecimationCode,
	output logic [11:0] sleepFlexIdleTime,
	// Output format settings
	output logic byteOrderSelect,
	output logic temperatureBurstInclude,
	output logic fastRead
);
	import arpm_pkg::*;

	// Stored fields of range_and_run_control
	logic [1:0] rangeField;
	logic activeBit;
	// Whole of power_mode_and_output_format
	logic [7:0] powerFormat;
	// Next values
	logic [1:0] next_rangeField;
	logic next_activeBit;
	logic [7:0] next_powerFormat;
	logic [7:0] next_regReadData;
	logic next_measureActive;
	logic [10:0] next_countsPerG;
	// Address hits
	logic hitRangeRun;
	logic hitPowerFmt;
	// Mode currently in force, after the pin override
	logic effectiveActive;

	// Sensitivity for a range code; shifts the 2 g figure right
	// A right shift keeps the table exact for all four codes
	function automatic logic [10:0] scaleFor(input logic [1:0] code);
		scaleFor = ARPM_COUNTS_2G >> code;
	endfunction

	// Address decode shared by reads and writes
	// Only two offsets are mapped; other writes are dropped
	assign hitRangeRun = (regAddr == ARPM_RANGE_RUN_ADDR);
	assign hitPowerFmt = (regAddr == ARPM_POWER_FMT_ADDR);

	// Pin level takes over the run decision while pin mode is on
	// The pin is used as is: it is taken to be synchronous to clk
	assign effectiveActive = pinModeControlEnable ? secondEventPin
		: activeBit;

	// Next values of the configuration fields
	always_comb begin
		// Hold every field unless a reset or a write moves it
		next_rangeField = rangeField;
		next_activeBit = activeBit;
		next_powerFormat = powerFormat;
		if (softReset) begin
			// Software reset restores defaults, hence standby
			next_rangeField = ARPM_RANGE_RESET;
			next_activeBit = ARPM_ACTIVE_RESET;
			next_powerFormat = ARPM_POWER_FMT_RESET;
		end else if (regWrite && hitRangeRun) begin
			// Range bits are written even while the run bit is locked
			next_rangeField =
				regWriteData[ARPM_RANGE_MSB:ARPM_RANGE_LSB];
			// Serial writes cannot move the bit under pin control; the
			// host is expected to order these writes itself
			if (!pinModeControlEnable) begin
				next_activeBit = regWriteData[ARPM_ACTIVE_BIT];
			end else begin
				// Stored bit kept, so it governs again once pin mode drops
				next_activeBit = activeBit;
			end
		end else if (regWrite && hitPowerFmt) begin
			// Every bit, the spare one included, is plain read/write
			next_powerFormat = regWriteData;
		end
	end

	// Configuration registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// Power-on reset loads the defaults, so standby
			rangeField <= ARPM_RANGE_RESET;
			activeBit <= ARPM_ACTIVE_RESET;
			powerFormat <= ARPM_POWER_FMT_RESET;
		end else begin
			// Plain register stage; every edge takes the next values
			rangeField <= next_rangeField;
			activeBit <= next_activeBit;
			powerFormat <= next_powerFormat;
		end
	end

	// Read mux; active bit reads the mode actually in force
	always_comb begin
		// Holding the old value keeps read data standing until next read
		next_regReadData = regReadData;
		if (regRead) begin
			// Fields are read before this edge's write lands, so a read
			// and a write in one cycle return the old contents
			if (hitRangeRun) begin
				// Unstored upper bits read as zero
				next_regReadData = 8'h00;
				next_regReadData[ARPM_RANGE_MSB:ARPM_RANGE_LSB] =
					rangeField;
				next_regReadData[ARPM_ACTIVE_BIT] = effectiveActive;
			end else if (hitPowerFmt) begin
				next_regReadData = powerFormat;
			end else begin
				// Unmapped offsets answer zero
				next_regReadData = ARPM_UNMAPPED_READ;
			end
		end
	end

	// Derived control outputs
	// Registered so they settle one cycle after the fields, glitch free
	always_comb begin
		next_measureActive = effectiveActive;
		next_countsPerG = scaleFor(rangeField);
	end

	// Read data and derived outputs held in flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// Reset values mirror the register defaults
			regReadData <= 8'h00;
			measureActive <= 1'b0;
			countsPerG <= ARPM_COUNTS_2G >> ARPM_RANGE_RESET;
		end else begin
			regReadData <= next_regReadData;
			measureActive <= next_measureActive;
			countsPerG <= next_countsPerG;
		end
	end

	// Range and format fields straight from their register bits
	// Format bits only steer the output path elsewhere; kept as plain
	// register bits so a read always shows what was written
	assign rangeSelect = rangeField;
	assign byteOrderSelect = powerFormat[ARPM_BYTEORDER_BIT];
	assign temperatureBurstInclude = powerFormat[ARPM_TEMPINC_BIT];
	assign fastRead = powerFormat[ARPM_FASTREAD_BIT];

	// Wake mode from the upper select field and upper rate nibble.
	// Motion-detect boot strap is not checked here: choosing the mode
	// stays the host's call.
	arpm_mode_decode wakeDecode (
		.clk(clk),
		.rstn(rstn),
		.powerSelect(powerFormat[ARPM_WAKEPM_MSB:ARPM_WAKEPM_LSB]),
		.rateNibble(rateDecimationConfig[7:4]),
		.idleTime(wakeIdleTime),
		.mode(wakeMode),
		.rateCode(wakeRateCode),
		.decimationCode(wakeDecimationCode),
		.flexIdleTime(wakeFlexIdleTime)
	);

	// Sleep mode from the lower select field and lower rate nibble
	// Sleep idle time is passed on only in flexible mode
	arpm_mode_decode sleepDecode (
		.clk(clk),
		.rstn(rstn),
		.powerSelect(powerFormat[ARPM_SLEEPPM_MSB:ARPM_SLEEPPM_LSB]),
		.rateNibble(rateDecimationConfig[3:0]),
		.idleTime(sleepIdleTime),
		.mode(sleepMode),
		.rateCode(sleepRateCode),
		.decimationCode(sleepDecimationCode),
		.flexIdleTime(sleepFlexIdleTime)
	);

endmodule

// ===== bench/arpm_config_monitor.sv
// Checker for the range and power-mode bank, watching its ports only.
// Assumes one clock domain and a bind from the testbench top.
`timescale 1ns/10ps
module arpm_config_monitor import arpm_pkg::*; (
	input wire logic clk, rstn, softReset, regWrite, regRead,
	input wire logic pinModeControlEnable, secondEventPin, measureActive,
	input wire logic byteOrderSelect, temperatureBurstInclude, fastRead,
	input wire logic [7:0] regAddr, regWriteData, regReadData,
	input wire logic [7:0] rateDecimationConfig,
	input wire logic [11:0] wakeIdleTime, wakeFlexIdleTime,
	input wire logic [1:0] rangeSelect,
	input wire logic [10:0] countsPerG,
	input wire logic [3:0] wakeDecimationCode, wakeRateCode,
	input wire logic [3:0] sleepDecimationCode, sleepRateCode,
	input arpm_mode_t wakeMode, sleepMode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Write to the run register that soft reset does not override
	wire w15 = regWrite && regAddr == ARPM_RANGE_RUN_ADDR && !softReset;
	wire w16 = regWrite && regAddr == ARPM_POWER_FMT_ADDR && !softReset;
	wire pm = pinModeControlEnable;
	// Active write, then a quiet cycle in which the stored bit governs
	sequence s_act;
		w15 && !pm ##1 !pm && !softReset;
	endsequence
	property p_cnt; countsPerG == ARPM_COUNTS_2G >> $past(rangeSelect);
	endproperty
	a_cnt: assert property (p_cnt) else $error("counts off");
	property p_rng; w15 |=> rangeSelect == $past(regWriteData[2:1]);
	endproperty
	a_rng: assert property (p_rng) else $error("range off");
	property p_act; s_act |=> measureActive == $past(regWriteData[0], 2);
	endproperty
	a_act: assert property (p_act) else $error("active off");
	property p_pin; pm && !softReset |=> measureActive == $past(secondEventPin);
	endproperty
	a_pin: assert property (p_pin) else $error("pin run off");
	property p_rdp; regRead && regAddr == ARPM_RANGE_RUN_ADDR && pm
		|=> regReadData[0] == $past(secondEventPin); endproperty
	a_rdp: assert property (p_rdp) else $error("pin read off");
	property p_fmt; w16 |=> {byteOrderSelect, temperatureBurstInclude,
		fastRead} == {$past(regWriteData[3]), $past(regWriteData[1:0])};
	endproperty
	a_fmt: assert property (p_fmt) else $error("format off");
	property p_srs; softReset |=> rangeSelect == ARPM_RANGE_RESET && !fastRead;
	endproperty
	a_srs: assert property (p_srs) else $error("soft reset off");
	property p_flx; wakeMode == ARPM_FLEXIBLE_MODE && $past(rstn) |->
		wakeDecimationCode == $past(rateDecimationConfig[7:4]) &&
		wakeRateCode == 4'h0 && wakeFlexIdleTime == $past(wakeIdleTime);
	endproperty
	a_flx: assert property (p_flx) else $error("flex off");
	property p_slp; sleepMode != ARPM_FLEXIBLE_MODE && $past(rstn) |->
		sleepRateCode == $past(rateDecimationConfig[3:0]) &&
		sleepDecimationCode == 4'h0; endproperty
	a_slp: assert property (p_slp) else $error("sleep off");
endmodule

// ===== bench/arpm_host_model.sv
// Host model: register accesses and the pin-mode inputs.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/10ps
module arpm_host_model import arpm_pkg::*; (
	input wire logic clk,
	output logic regWrite, regRead, softReset,
	output logic pinModeControlEnable, secondEventPin,
	output logic [7:0] regAddr, regWriteData
);
	logic [7:0] expQ[$]; // Expected read data, oldest first
	logic actSet = 1'b0; // Shadow of the active bit the host wrote
	initial {regWrite, regRead, softReset, regAddr, regWriteData} = '0;
	initial {pinModeControlEnable, secondEventPin} = 2'h0;
	// One strobed cycle, then strobes low for a cycle
	task automatic op(input logic w, r, s, input logic [7:0] a, dt);
		@(negedge clk);
		{regWrite, regRead, softReset, regAddr, regWriteData} = {w, r, s, a, dt};
		@(negedge clk);
		{regWrite, regRead, softReset} = 3'h0;
	endtask
	// Boot-mode pin is not modelled, so no mode advice applies
	task automatic wr(input logic [7:0] a, dt);
		// Never ask for active while pin mode is on
		if (a == ARPM_RANGE_RUN_ADDR && pinModeControlEnable) begin
			dt[0] = 1'b0;
		end
		if (a == ARPM_RANGE_RUN_ADDR) actSet = dt[0];
		op(1'b1, 1'b0, 1'b0, a, dt);
	endtask
	task automatic rd(input logic [7:0] a, e);
		expQ.push_back(e);
		op(1'b0, 1'b1, 1'b0, a, 8'h00);
	endtask
	// Pin mode is only turned on while the active bit is clear
	task automatic pin(input logic en, lvl);
		@(negedge clk);
		pinModeControlEnable = en && !actSet;
		secondEventPin = lvl;
	endtask
endmodule

// ===== bench/arpm_config_regs_tb.sv
// Self-checking bench for the configuration bank and its host model.
// Assumes a free-running 125 MHz clock; reads are checked from a queue.
`timescale 1ns/10ps
module arpm_config_regs_tb;
	import arpm_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, rdSeen = 1'b0;
	logic regWrite, regRead, softReset, pinModeControlEnable, secondEventPin;
	logic measureActive, byteOrderSelect, temperatureBurstInclude, fastRead;
	logic [7:0] regAddr, regWriteData, regReadData, d;
	logic [7:0] rateDecimationConfig = 8'h00;
	logic [11:0] wakeIdleTime = 12'h000, sleepIdleTime = 12'h000;
	logic [11:0] wakeFlexIdleTime, sleepFlexIdleTime;
	logic [1:0] rangeSelect;
	logic [10:0] countsPerG;
	logic [3:0] wakeRateCode, wakeDecimationCode, sleepRateCode;
	logic [3:0] sleepDecimationCode;
	arpm_mode_t wakeMode, sleepMode;
	int err_count = 0, total_checks = 0, seed = 70835;
	arpm_config_regs dut_u (
		.clk(clk),
		.rstn(rstn),
		.softReset(softReset),
		.regWrite(regWrite),
		.regRead(regRead),
		.regAddr(regAddr),
		.regWriteData(regWriteData),
		.regReadData(regReadData),
		.pinModeControlEnable(pinModeControlEnable),
		.secondEventPin(secondEventPin),
		.rateDecimationConfig(rateDecimationConfig),
		.wakeIdleTime(wakeIdleTime),
		.sleepIdleTime(sleepIdleTime),
		.measureActive(measureActive),
		.rangeSelect(rangeSelect),
		.countsPerG(countsPerG),
		.wakeMode(wakeMode),
		.wakeRateCode(wakeRateCode),
		.wakeDecimationCode(wakeDecimationCode),
		.wakeFlexIdleTime(wakeFlexIdleTime),
		.sleepMode(sleepMode),
		.sleepRateCode(sleepRateCode),
		.sleepDecimationCode(sleepDecimationCode),
		.sleepFlexIdleTime(sleepFlexIdleTime),
		.byteOrderSelect(byteOrderSelect),
		.temperatureBurstInclude(temperatureBurstInclude),
		.fastRead(fastRead)
	);
	arpm_host_model host_u (
		.clk(clk),
		.regWrite(regWrite),
		.regRead(regRead),
		.softReset(softReset),
		.pinModeControlEnable(pinModeControlEnable),
		.secondEventPin(secondEventPin),
		.regAddr(regAddr),
		.regWriteData(regWriteData)
	);
	initial forever #4 clk = ~clk;
	task automatic chk(input string n, input logic [11:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic arpm_mode_t em(input logic [1:0] p);
		if (p[1]) return ARPM_FLEXIBLE_MODE;
		return p[0] ? ARPM_HIGH_PERFORMANCE_MODE : ARPM_LOW_POWER_MODE;
	endfunction
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Read data is valid the cycle after the strobe edge
	always @(posedge clk) rdSeen <= regRead;
	// Looked at half a cycle after it was launched, while it stands
	always @(negedge clk) begin
		if (rdSeen) begin
			chk("read", host_u.expQ.pop_front(), regReadData);
		end
	end
	initial begin
		#20000;
		err_count++;
		complete_run;
	end
	initial begin
		cyc(5);
		rstn = 1'b1;
		chk("range", ARPM_RANGE_RESET, rangeSelect);
		host_u.rd(ARPM_RANGE_RUN_ADDR, 8'h02);
		host_u.rd(ARPM_POWER_FMT_ADDR, 8'h00);
		host_u.rd(8'h17, ARPM_UNMAPPED_READ);
		for (int r = 0; r < 4; r++) begin
			host_u.wr(ARPM_RANGE_RUN_ADDR, 8'(r * 2));
			cyc(1);
			chk("counts", ARPM_COUNTS_2G >> r, countsPerG);
			host_u.rd(ARPM_RANGE_RUN_ADDR, 8'(r * 2));
		end
		host_u.wr(ARPM_RANGE_RUN_ADDR, 8'h07);
		cyc(1);
		chk("active", 1, measureActive);
		host_u.wr(ARPM_RANGE_RUN_ADDR, 8'h06);
		cyc(1);
		chk("active", 0, measureActive);
		$display("range and run test done");
		host_u.pin(1'b1, 1'b1);
		cyc(1);
		chk("active", 1, measureActive);
		host_u.rd(ARPM_RANGE_RUN_ADDR, 8'h07);
		// Blocked attempt to set the active bit under pin control
		host_u.op(1'b1, 1'b0, 1'b0, ARPM_RANGE_RUN_ADDR, 8'h01);
		host_u.pin(1'b1, 1'b0);
		cyc(1);
		chk("active", 0, measureActive);
		host_u.pin(1'b0, 1'b0);
		cyc(2);
		chk("active", 0, measureActive);
		host_u.rd(ARPM_RANGE_RUN_ADDR, 8'h00);
		$display("pin mode test done");
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			d[7:4] = {i[1:0], i[2:1]};
			@(negedge clk);
			rateDecimationConfig = 8'($random(seed));
			wakeIdleTime = 12'($random(seed));
			sleepIdleTime = 12'($random(seed));
			host_u.wr(ARPM_POWER_FMT_ADDR, d);
			cyc(1);
			chk("wake", em(d[7:6]), wakeMode);
			chk("sleep", em(d[5:4]), sleepMode);
			chk("format", d[3:0] & 4'hb, {byteOrderSelect, 1'b0,
				temperatureBurstInclude, fastRead});
			chk("wcode", d[7] ? {rateDecimationConfig[7:4], 4'h0} :
				{4'h0, rateDecimationConfig[7:4]},
				{wakeDecimationCode, wakeRateCode});
			chk("widle", d[7] ? wakeIdleTime : 12'h000, wakeFlexIdleTime);
			chk("scode", d[5] ? {rateDecimationConfig[3:0], 4'h0} :
				{4'h0, rateDecimationConfig[3:0]},
				{sleepDecimationCode, sleepRateCode});
			chk("sidle", d[5] ? sleepIdleTime : 12'h000,
				sleepFlexIdleTime);
			host_u.rd(ARPM_POWER_FMT_ADDR, d);
		end
		$display("power mode test done");
		host_u.wr(ARPM_RANGE_RUN_ADDR, 8'h01);
		host_u.op(1'b1, 1'b0, 1'b1, ARPM_POWER_FMT_ADDR, 8'h5a);
		cyc(1);
		chk("range", ARPM_RANGE_RESET, rangeSelect);
		chk("active", 0, measureActive);
		host_u.rd(ARPM_POWER_FMT_ADDR, 8'h00);
		$display("soft reset test done");
		cyc(2);
		complete_run;
	end
endmodule
bind arpm_config_regs arpm_config_monitor mon_u (
	.clk(clk),
	.rstn(rstn),
	.softReset(softReset),
	.regWrite(regWrite),
	.regRead(regRead),
	.pinModeControlEnable(pinModeControlEnable),
	.secondEventPin(secondEventPin),
	.measureActive(measureActive),
	.byteOrderSelect(byteOrderSelect),
	.temperatureBurstInclude(temperatureBurstInclude),
	.fastRead(fastRead),
	.regAddr(regAddr),
	.regWriteData(regWriteData),
	.regReadData(regReadData),
	.rateDecimationConfig(rateDecimationConfig),
	.wakeIdleTime(wakeIdleTime),
	.wakeFlexIdleTime(wakeFlexIdleTime),
	.rangeSelect(rangeSelect),
	.countsPerG(countsPerG),
	.wakeDecimationCode(wakeDecimationCode),
	.wakeRateCode(wakeRateCode),
	.sleepDecimationCode(sleepDecimationCode),
	.sleepRateCode(sleepRateCode),
	.wakeMode(wakeMode),
	.sleepMode(sleepMode)
);
